// ### src/dual_nibble_timer_bc.sv
/*
 * Timers B and C with their nibble-wide mode, preload and count registers,
 * interrupt and capture flags, watchdog reset request and PWM output pin,
 * reached over an APB slave with one extra wait state.
 * Assumes EVENT_IN is synchronous to REF_CLK and that the system resets the
 * block through NRST when WATCHDOG_RESET pulses.
 */
`timescale 1ns/1ns

// Notes on behaviour
// R01 - Timer B mode one: bit 3 reload, bits 2-0 prescale ratio or event pin.
// R02 - Timer B mode two: three write-only bits, edge and capture, reset zero.
// R03 - Timer B preload low nibble resets to zero; upper nibble undefined.
// R04 - Low preload write alone keeps count; upper write loads all 8 bits.
// R05 - Software writes the low preload nibble before the upper one.
// R06 - Upper-only rewrite loads the new upper with the stored lower nibble.
// R07 - Upper count read gives live upper and latches lower for later read.
// R08 - Software reads the upper count nibble first for a coherent value.
// R09 - After a capture, both captured nibbles read alike in either order.
// R10 - Timer C counts from preload; at FF it overflows, reloads or wraps.
// R11 - Timer C overflow sets its interrupt flag; software or reset clears.
// R12 - With watchdog on, a timer C overflow requests an MCU reset.
// R13 - Software refreshes timer C so it never reaches FF under watchdog.
// R14 - Port mode A selects the timer C output pin; reset drives it low.
// R15 - PWM pulse period and duty follow timer C mode and preload.
// R16 - Timer C mode: four write-only bits, reload and clock, reset zero.
// R17 - Timer C mode writes take effect from the second cycle after.
// R18 - Software writes timer C preload only after a mode change settles.
// R19 - Timer C preload pair resets and behaves like timer B's pair.
// R20 - Timer C upper count read latches the lower count like timer B.
// R21 - Low-only timer C preload write keeps count; upper write loads it.
// R22 - Software ignores PWM after a preload change until next overflow.
// R23 - Timer B overflows at FF, reloads or wraps, and sets its flag.
// R24 - Capture edge copies count, sets flags, clears counter, keeps counting.
// R25 - Trigger or overflow while capture status set sets capture error.
// R26 - One clock domain; counters advance on prescaler or event enables, timer C at clock select 7 on every clock.
module dual_nibble_timer_bc (
    // Clock and reset
    input  wire logic                               REF_CLK,
    input  wire logic                               NRST,
    // APB slave
    input  wire logic                               PSEL,
    input  wire logic                               PENABLE,
    input  wire logic                               PWRITE,
    input  wire logic [timer_bc_pkg::ADDR_W-1:0]    PADDR,
    input  wire logic [timer_bc_pkg::DATA_W-1:0]    PWDATA,
    output logic      [timer_bc_pkg::DATA_W-1:0]    PRDATA,
    output logic                                    PREADY,
    output logic                                    PSLVERR,
    // Event pin
    input  wire logic                               EVENT_IN,
    // Timer C output pin
    output logic                                    TOC_OUT,
    output logic                                    TOC_OE,
    // Status towards the rest of the MCU
    output logic                                    TB_IRQ_FLAG,
    output logic                                    TC_IRQ_FLAG,
    output logic                                    WATCHDOG_RESET
);

    localparam int NW = timer_bc_pkg::NIB_W;

    // Bus decode
    logic [timer_bc_pkg::IDX_W-1:0] idx;
    logic                           addr_ok;
    logic                           mapped;
    logic                           acc;
    logic                           wr;
    logic                           rd_acc;
    logic [NW-1:0]                  rd_value;
    logic [NW-1:0]                  wnib;

    // Control registers
    logic [NW-1:0]                  port_mode_a;
    logic [NW-1:0]                  port_mode_b;
    timer_bc_pkg::tb_mode_two_t     tb_mode_two;
    logic [NW-1:0]                  tb_preload_lo;
    logic [NW-1:0]                  tb_preload_hi;
    logic [NW-1:0]                  tc_preload_lo;
    logic [NW-1:0]                  tc_preload_hi;
    logic                           watchdog_on_flag;
    logic                           capture_status_flag;
    logic                           capture_error_flag;

    // Timer state
    logic [timer_bc_pkg::PSC_W-1:0] psc;
    timer_bc_pkg::mode_t            tb_mode_one;
    timer_bc_pkg::mode_t            tc_mode;
    logic [timer_bc_pkg::CNT_W-1:0] tb_count;
    logic [timer_bc_pkg::CNT_W-1:0] tc_count;
    logic [timer_bc_pkg::CNT_W-1:0] tb_read;
    logic [timer_bc_pkg::CNT_W-1:0] tc_read;
    logic [timer_bc_pkg::CNT_W-1:0] tb_preload;
    logic [timer_bc_pkg::CNT_W-1:0] tc_preload;
    logic                           tb_ovf;
    logic                           tc_ovf;
    logic                           tb_tick;
    logic                           tc_tick;
    logic                           tb_load;
    logic                           tc_load;
    logic                           capture_trig;
    logic                           pwm;

    // Event pin edge detection
    logic                           ev_sync1;
    logic                           ev_sync2;
    logic                           ev_prev;
    logic                           ev_rise;
    logic                           ev_fall;
    logic                           ev_hit;

    // Write strobes
    logic                           wr_flags;
    logic                           wr_pma;
    logic                           wr_pmb;
    logic                           wr_tb_mode_one;
    logic                           wr_tb_mode_two;
    logic                           wr_tb_lo;
    logic                           wr_tb_hi;
    logic                           wr_tc_mode;
    logic                           wr_tc_lo;
    logic                           wr_tc_hi;
    logic                           wr_wd;
    logic                           wr_cap;

    assign idx     = PADDR[timer_bc_pkg::ADDR_W-1:2];
    assign addr_ok = (PADDR[1:0] == 2'h0);
    assign wnib    = PWDATA[NW-1:0];

    // First access cycle computes the answer; the write lands when it completes
    assign acc    = PSEL && PENABLE && !PREADY;
    assign rd_acc = acc && !PWRITE && addr_ok && mapped;
    assign wr     = PSEL && PENABLE && PREADY && PWRITE && !PSLVERR;

    assign wr_flags       = wr && (idx == timer_bc_pkg::IDX_IRQ_FLAGS);
    assign wr_pma         = wr && (idx == timer_bc_pkg::IDX_PORT_MODE_A);
    assign wr_pmb         = wr && (idx == timer_bc_pkg::IDX_PORT_MODE_B);
    assign wr_tb_mode_one = wr && (idx == timer_bc_pkg::IDX_TB_MODE_ONE);
    assign wr_tb_mode_two = wr && (idx == timer_bc_pkg::IDX_TB_MODE_TWO);
    assign wr_tb_lo       = wr && (idx == timer_bc_pkg::IDX_TB_LO);
    assign wr_tb_hi       = wr && (idx == timer_bc_pkg::IDX_TB_HI);
    assign wr_tc_mode     = wr && (idx == timer_bc_pkg::IDX_TC_MODE);
    assign wr_tc_lo       = wr && (idx == timer_bc_pkg::IDX_TC_LO);
    assign wr_tc_hi       = wr && (idx == timer_bc_pkg::IDX_TC_HI);
    assign wr_wd          = wr && (idx == timer_bc_pkg::IDX_WATCHDOG);
    assign wr_cap         = wr && (idx == timer_bc_pkg::IDX_CAPTURE_FLAGS);

    // Read mux; write-only registers read as zero
    always_comb
    begin
        rd_value = timer_bc_pkg::NIB_RESET;
        mapped   = 1'b1;
        case (idx)
            timer_bc_pkg::IDX_IRQ_FLAGS:
            begin
                rd_value[timer_bc_pkg::TB_IRQ_BIT] = TB_IRQ_FLAG;
                rd_value[timer_bc_pkg::TC_IRQ_BIT] = TC_IRQ_FLAG;
            end
            timer_bc_pkg::IDX_TB_LO:
                rd_value = tb_read[NW-1:0]; // R07 R09
            timer_bc_pkg::IDX_TB_HI:
                rd_value = tb_mode_two.capture_en ? tb_read[2*NW-1:NW]
                                                  : tb_count[2*NW-1:NW]; // R07 R09
            timer_bc_pkg::IDX_TC_LO:
                rd_value = tc_read[NW-1:0]; // R20
            timer_bc_pkg::IDX_TC_HI:
                rd_value = tc_count[2*NW-1:NW]; // R20
            timer_bc_pkg::IDX_WATCHDOG:
                rd_value[timer_bc_pkg::WATCHDOG_BIT] = watchdog_on_flag;
            timer_bc_pkg::IDX_CAPTURE_FLAGS:
            begin
                rd_value[timer_bc_pkg::CAP_STATUS_BIT] = capture_status_flag;
                rd_value[timer_bc_pkg::CAP_ERROR_BIT]  = capture_error_flag;
            end
            timer_bc_pkg::IDX_PORT_MODE_A,
            timer_bc_pkg::IDX_PORT_MODE_B,
            timer_bc_pkg::IDX_TB_MODE_ONE,
            timer_bc_pkg::IDX_TB_MODE_TWO,
            timer_bc_pkg::IDX_TC_MODE:
                rd_value = timer_bc_pkg::NIB_RESET;
            default:
                mapped = 1'b0;
        endcase
    end

    // APB answer, one wait state
    always_ff @(posedge REF_CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            PREADY  <= 1'b0;
            PSLVERR <= 1'b0;
            PRDATA  <= '0;
        end
        else if (acc)
        begin
            PREADY  <= 1'b1;
            PSLVERR <= !(addr_ok && mapped);
            PRDATA  <= {{(timer_bc_pkg::DATA_W-NW){1'b0}}, rd_value};
        end
        else
        begin
            PREADY  <= 1'b0;
            PSLVERR <= 1'b0;
        end
    end

    // Port mode and timer B mode two registers
    always_ff @(posedge REF_CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            port_mode_a <= timer_bc_pkg::NIB_RESET;
            port_mode_b <= timer_bc_pkg::NIB_RESET;
            tb_mode_two <= timer_bc_pkg::tb_mode_two_t'(3'h0); // R02
        end
        else
        begin
            if (wr_pma)
                port_mode_a <= wnib;
            if (wr_pmb)
                port_mode_b <= wnib;
            if (wr_tb_mode_two)
                tb_mode_two <= timer_bc_pkg::tb_mode_two_t'(wnib[2:0]); // R02
        end
    end

    // Preload nibble pairs
    always_ff @(posedge REF_CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            tb_preload_lo <= timer_bc_pkg::NIB_RESET; // R03
            tb_preload_hi <= timer_bc_pkg::NIB_RESET; // R03
            tc_preload_lo <= timer_bc_pkg::NIB_RESET; // R19
            tc_preload_hi <= timer_bc_pkg::NIB_RESET; // R19
        end
        else
        begin
            if (wr_tb_lo)
                tb_preload_lo <= wnib;
            if (wr_tb_hi)
                tb_preload_hi <= wnib;
            if (wr_tc_lo)
                tc_preload_lo <= wnib;
            if (wr_tc_hi)
                tc_preload_hi <= wnib;
        end
    end

    // On an upper write the new nibble joins the stored lower one
    assign tb_load    = wr_tb_hi; // R04 R06
    assign tc_load    = wr_tc_hi; // R19 R21
    assign tb_preload = tb_load ? {wnib, tb_preload_lo} : {tb_preload_hi, tb_preload_lo}; // R06
    assign tc_preload = tc_load ? {wnib, tc_preload_lo} : {tc_preload_hi, tc_preload_lo}; // R19

    // Free-running prescaler
    always_ff @(posedge REF_CLK or negedge NRST)
    begin
        if (!NRST)
            psc <= '0;
        else
            psc <= psc + 1'b1; // R26
    end

    // Event pin: two-stage synchroniser, then edge detection on the second stage
    always_ff @(posedge REF_CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            ev_sync1 <= 1'b0;
            ev_sync2 <= 1'b0;
            ev_prev  <= 1'b0;
        end
        else
        begin
            ev_sync1 <= EVENT_IN;
            ev_sync2 <= ev_sync1;
            ev_prev  <= ev_sync2;
        end
    end

    assign ev_rise = ev_sync2 && !ev_prev;
    assign ev_fall = !ev_sync2 && ev_prev;
    assign ev_hit  = port_mode_b[timer_bc_pkg::EVENT_SELECT_BIT] && (
                     (ev_rise && (tb_mode_two.edge_sel == timer_bc_pkg::EDGE_RISE ||
                                  tb_mode_two.edge_sel == timer_bc_pkg::EDGE_BOTH)) ||
                     (ev_fall && (tb_mode_two.edge_sel == timer_bc_pkg::EDGE_FALL ||
                                  tb_mode_two.edge_sel == timer_bc_pkg::EDGE_BOTH))); // R26

    // Clock selection
    assign tb_tick = (tb_mode_one.clk_sel == timer_bc_pkg::CLK_EXTERNAL)
                   ? (ev_hit && !tb_mode_two.capture_en)
                   : timer_bc_pkg::tap_tick(tb_mode_one.clk_sel, psc); // R01 R26
    assign tc_tick = (tc_mode.clk_sel == timer_bc_pkg::CLK_EXTERNAL)
                   ? 1'b1
                   : timer_bc_pkg::tap_tick(tc_mode.clk_sel, psc); // R16 R26
    assign capture_trig = tb_mode_two.capture_en && ev_hit &&
                          (tb_mode_one.clk_sel != timer_bc_pkg::CLK_EXTERNAL); // R24

    reload_counter #(
        .WIDTH     (timer_bc_pkg::CNT_W)
    ) timer_b (
        .clk       (REF_CLK),
        .nrst      (NRST),
        .mode_wr   (wr_tb_mode_one),
        .mode_data (timer_bc_pkg::mode_t'(wnib)),
        .mode      (tb_mode_one),
        .tick      (tb_tick),
        .load      (tb_load),
        .clear     (capture_trig),
        .preload   (tb_preload),
        .count     (tb_count),
        .overflow  (tb_ovf)
    );

    reload_counter #(
        .WIDTH     (timer_bc_pkg::CNT_W)
    ) timer_c (
        .clk       (REF_CLK),
        .nrst      (NRST),
        .mode_wr   (wr_tc_mode),
        .mode_data (timer_bc_pkg::mode_t'(wnib)),
        .mode      (tc_mode),
        .tick      (tc_tick),
        .load      (tc_load),
        .clear     (1'b0),
        .preload   (tc_preload),
        .count     (tc_count),
        .overflow  (tc_ovf)
    );

    // Read latches: capture has priority over the upper-read latch
    always_ff @(posedge REF_CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            tb_read <= timer_bc_pkg::CNT_RESET;
            tc_read <= timer_bc_pkg::CNT_RESET;
        end
        else
        begin
            if (capture_trig)
                tb_read <= tb_count; // R24 R09
            else if (rd_acc && idx == timer_bc_pkg::IDX_TB_HI && !tb_mode_two.capture_en)
                tb_read[NW-1:0] <= tb_count[NW-1:0]; // R07
            if (rd_acc && idx == timer_bc_pkg::IDX_TC_HI)
                tc_read[NW-1:0] <= tc_count[NW-1:0]; // R20
        end
    end

    // Interrupt flags: hardware set wins over a software clear
    always_ff @(posedge REF_CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            TB_IRQ_FLAG <= 1'b0;
            TC_IRQ_FLAG <= 1'b0;
        end
        else
        begin
            if (tb_ovf || capture_trig)
                TB_IRQ_FLAG <= 1'b1; // R23 R24
            else if (wr_flags && !wnib[timer_bc_pkg::TB_IRQ_BIT])
                TB_IRQ_FLAG <= 1'b0;
            if (tc_ovf)
                TC_IRQ_FLAG <= 1'b1; // R11
            else if (wr_flags && !wnib[timer_bc_pkg::TC_IRQ_BIT])
                TC_IRQ_FLAG <= 1'b0; // R11
        end
    end

    // Capture status and error flags
    always_ff @(posedge REF_CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            capture_status_flag <= 1'b0;
            capture_error_flag  <= 1'b0;
        end
        else
        begin
            if (capture_trig)
                capture_status_flag <= 1'b1; // R24
            else if (wr_cap && !wnib[timer_bc_pkg::CAP_STATUS_BIT])
                capture_status_flag <= 1'b0;
            if (capture_status_flag && (capture_trig || tb_ovf))
                capture_error_flag <= 1'b1; // R25
            else if (wr_cap && !wnib[timer_bc_pkg::CAP_ERROR_BIT])
                capture_error_flag <= 1'b0;
        end
    end

    // Watchdog enable and reset request
    always_ff @(posedge REF_CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            watchdog_on_flag <= 1'b0;
            WATCHDOG_RESET   <= 1'b0;
        end
        else
        begin
            if (wr_wd)
                watchdog_on_flag <= wnib[timer_bc_pkg::WATCHDOG_BIT];
            WATCHDOG_RESET <= tc_ovf && watchdog_on_flag; // R12
        end
    end

    // PWM: reload mode is high for the input period at FF, free-running is
    // high while the count is below the preload
    assign pwm = tc_mode.reload ? (tc_count == {timer_bc_pkg::CNT_W{1'b1}})
                                : (tc_count < {tc_preload_hi, tc_preload_lo}); // R15

    always_ff @(posedge REF_CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            TOC_OUT <= 1'b0; // R14
            TOC_OE  <= 1'b0;
        end
        else
        begin
            TOC_OE  <= port_mode_a[timer_bc_pkg::TOC_SELECT_BIT]; // R14
            TOC_OUT <= port_mode_a[timer_bc_pkg::TOC_SELECT_BIT] && pwm; // R14 R15
        end
    end

endmodule

// ### src/timer_bc_pkg.sv
/*
 * Shared constants and types for the dual 8-bit timer block (timers B and C):
 * register indices, field positions, reset values, mode layouts and the
 * prescaler tap decoder.
 * Assumes one system clock; each register index is a 32-bit APB word at
 * byte address four times the index.
 */
package timer_bc_pkg;

    localparam int ADDR_W   = 12;
    localparam int DATA_W   = 32;
    localparam int IDX_W    = 10;
    localparam int NIB_W    = 4;
    localparam int CNT_W    = 8;
    localparam int PSC_W    = 11;

    // Register indices (byte address = index * 4)
    localparam logic [IDX_W-1:0] IDX_IRQ_FLAGS     = 10'h002;
    localparam logic [IDX_W-1:0] IDX_PORT_MODE_A   = 10'h004;
    localparam logic [IDX_W-1:0] IDX_TB_MODE_ONE   = 10'h009;
    localparam logic [IDX_W-1:0] IDX_TB_LO         = 10'h00a;
    localparam logic [IDX_W-1:0] IDX_TB_HI         = 10'h00b;
    localparam logic [IDX_W-1:0] IDX_TC_MODE       = 10'h00d;
    localparam logic [IDX_W-1:0] IDX_TC_LO         = 10'h00e;
    localparam logic [IDX_W-1:0] IDX_TC_HI         = 10'h00f;
    localparam logic [IDX_W-1:0] IDX_WATCHDOG      = 10'h020;
    localparam logic [IDX_W-1:0] IDX_CAPTURE_FLAGS = 10'h021;
    localparam logic [IDX_W-1:0] IDX_PORT_MODE_B   = 10'h024;
    localparam logic [IDX_W-1:0] IDX_TB_MODE_TWO   = 10'h026;

    // Field positions
    localparam int TB_IRQ_BIT       = 0;
    localparam int TC_IRQ_BIT       = 2;
    localparam int WATCHDOG_BIT     = 1;
    localparam int CAP_STATUS_BIT   = 0;
    localparam int CAP_ERROR_BIT    = 1;
    localparam int TOC_SELECT_BIT   = 3;
    localparam int EVENT_SELECT_BIT = 0;

    // Reset values
    localparam logic [NIB_W-1:0] NIB_RESET = 4'h0;
    localparam logic [CNT_W-1:0] CNT_RESET = 8'h00;

    // A mode register write becomes active this many cycles later
    localparam logic [1:0] MODE_DELAY = 2'h2;

    localparam logic [2:0] CLK_EXTERNAL = 3'h7;

    typedef enum logic [1:0] {
        EDGE_NONE,
        EDGE_FALL,
        EDGE_RISE,
        EDGE_BOTH
    } edge_t;

    typedef struct packed {
        logic       reload;
        logic [2:0] clk_sel;
    } mode_t;

    typedef struct packed {
        logic  capture_en;
        edge_t edge_sel;
    } tb_mode_two_t;

    localparam mode_t MODE_RESET = 4'h0;

    // Prescaler tap: one-cycle enable every 2048/512/128/32/8/4/2 cycles
    function automatic logic tap_tick(logic [2:0] sel, logic [PSC_W-1:0] psc);
        logic [PSC_W-1:0] mask;
        mask = 11'h000;
        case (sel)
            3'h0:    mask = 11'h7ff;
            3'h1:    mask = 11'h1ff;
            3'h2:    mask = 11'h07f;
            3'h3:    mask = 11'h01f;
            3'h4:    mask = 11'h007;
            3'h5:    mask = 11'h003;
            3'h6:    mask = 11'h001;
            default: mask = 11'h000;
        endcase
        return (psc & mask) == mask;
    endfunction

endpackage

// ### src/reload_counter.sv
/*
 * 8-bit up-counter with preload, clear, free-running or reload wrap, and a
 * mode register whose writes become active after a fixed delay.
 * Assumes tick, load and clear are one-cycle pulses on the system clock.
 */
`timescale 1ns/1ns
module reload_counter #(
    parameter int WIDTH = 8
) (
    // Clock and reset
    input  wire logic                 clk,
    input  wire logic                 nrst,
    // Mode register
    input  wire logic                 mode_wr,
    input  wire timer_bc_pkg::mode_t  mode_data,
    output timer_bc_pkg::mode_t       mode,
    // Counting
    input  wire logic                 tick,
    input  wire logic                 load,
    input  wire logic                 clear,
    input  wire logic [WIDTH-1:0]     preload,
    output logic      [WIDTH-1:0]     count,
    output logic                      overflow
);

    localparam logic [WIDTH-1:0] CNT_MAX = {WIDTH{1'b1}};

    timer_bc_pkg::mode_t mode_pend;
    logic [1:0]          mode_delay;

    // Mode write held back until the delay runs out
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            mode_pend  <= timer_bc_pkg::MODE_RESET;
            mode_delay <= 2'h0;
            mode       <= timer_bc_pkg::MODE_RESET;
        end
        else if (mode_wr)
        begin
            mode_pend  <= mode_data;
            mode_delay <= timer_bc_pkg::MODE_DELAY;
        end
        else if (mode_delay != 2'h0)
        begin
            mode_delay <= mode_delay - 2'h1;
            if (mode_delay == 2'h1)
                mode <= mode_pend; // R17
        end
    end

    assign overflow = tick && !load && !clear && (count == CNT_MAX); // R10 R23

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            count <= {WIDTH{1'b0}};
        else if (load)
            count <= preload; // R04 R21
        else if (clear)
            count <= {WIDTH{1'b0}};
        else if (tick)
        begin
            if (count == CNT_MAX)
                count <= mode.reload ? preload : {WIDTH{1'b0}}; // R10 R23
            else
                count <= count + 1'b1;
        end
    end

endmodule

// ### dv/timer_bc_assertions.sv
/* Port-level checks for the dual timer block.
   Assumes one clock REF_CLK and the asynchronous active-low NRST. */
`timescale 1ns/1ns
module timer_bc_assertions (
    // Clock, reset and APB
    input wire logic                            REF_CLK, NRST, PSEL, PENABLE, PWRITE,
    input wire logic [timer_bc_pkg::ADDR_W-1:0] PADDR,
    input wire logic [timer_bc_pkg::DATA_W-1:0] PRDATA,
    input wire logic                            PREADY, PSLVERR,
    // Pin and status outputs
    input wire logic                            TOC_OUT, TOC_OE, TB_IRQ_FLAG, TC_IRQ_FLAG,
    input wire logic                            WATCHDOG_RESET
);
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (!NRST);
    wire done_wr = PSEL && PENABLE && PREADY && PWRITE;
    sequence s_wait;
        PSEL && PENABLE && !PREADY;
    endsequence
    sequence s_answer;
        PREADY ##1 !PREADY;
    endsequence
    a_ready_wait: assert property (s_wait |=> s_answer)
        else $error("access phase not answered after one wait state");
    a_wo_read: assert property (PREADY && !PWRITE && PADDR == 12'h034 |-> PRDATA == 32'h0 && !PSLVERR)
        else $error("mode register read not zero");
    a_unmapped_err: assert property (PREADY && PADDR == 12'h0fc |-> PSLVERR && PRDATA == 32'h0)
        else $error("unmapped access not refused");
    a_toc_low: assert property (!TOC_OE && !$past(TOC_OE) |-> !TOC_OUT)
        else $error("timer output high while pin not selected");
    a_toc_select: assert property ($rose(TOC_OE) |-> $past(done_wr && PADDR == 12'h010, 2))
        else $error("pin select changed without a write");
    a_tc_clear: assert property ($fell(TC_IRQ_FLAG) |-> $past(done_wr && PADDR == 12'h008))
        else $error("timer C flag cleared without a write");
    a_tb_clear: assert property ($fell(TB_IRQ_FLAG) |-> $past(done_wr && PADDR == 12'h008))
        else $error("timer B flag cleared without a write");
    a_wd_flag: assert property (WATCHDOG_RESET |-> TC_IRQ_FLAG)
        else $error("watchdog reset without timer C overflow");
endmodule

bind dual_nibble_timer_bc timer_bc_assertions timer_bc_assertions_i (.REF_CLK, .NRST,
    .PSEL, .PENABLE, .PWRITE, .PADDR, .PRDATA, .PREADY, .PSLVERR, .TOC_OUT, .TOC_OE,
    .TB_IRQ_FLAG, .TC_IRQ_FLAG, .WATCHDOG_RESET);

// ### dv/dual_nibble_timer_bc_bench.sv
/* Self-checking bench for the dual timer block, driven over APB.
   Assumes the one-wait-state APB slave and a 100 MHz REF_CLK. */
`timescale 1ns/1ns
module dual_nibble_timer_bc_bench;
    logic        REF_CLK = 1'b0, NRST = 1'b0, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
    logic [11:0] PADDR = 12'h000;
    logic [31:0] PWDATA = 32'h0, PRDATA;
    logic        EVENT_IN = 1'b0, PREADY, PSLVERR, TOC_OUT, TOC_OE;
    logic        TB_IRQ_FLAG, TC_IRQ_FLAG, WATCHDOG_RESET;
    logic [11:0] b;
    int          errors = 0, num_checks = 0, cycles = 0, wd_seen = 0;
    dual_nibble_timer_bc dual_nibble_timer_bc_i (.REF_CLK, .NRST, .PSEL, .PENABLE, .PWRITE,
        .PADDR, .PWDATA, .PRDATA, .PREADY, .PSLVERR, .EVENT_IN, .TOC_OUT, .TOC_OE,
        .TB_IRQ_FLAG, .TC_IRQ_FLAG, .WATCHDOG_RESET);
    always #5 REF_CLK = ~REF_CLK;
    always @(posedge REF_CLK)
    begin
        cycles++;
        if (WATCHDOG_RESET === 1'b1) wd_seen++;
        if (cycles == 5000)
        begin
            errors++;
            final_report;
        end
    end
    task final_report;
        if (errors == 0 && num_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // One APB transfer; held until PREADY is sampled high
    task xfer(input logic [11:0] a, input logic w, input logic [31:0] d, output logic [31:0] q);
        @(posedge REF_CLK);
        PSEL <= 1'b1;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge REF_CLK);
        PENABLE <= 1'b1;
        do @(posedge REF_CLK); while (PREADY !== 1'b1);
        q = PRDATA;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
    endtask
    task wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        xfer(a, 1'b1, d, q);
    endtask
    task rd(input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] q;
        xfer(a, 1'b0, 32'h0, q);
        chk(q, exp);
    endtask
    initial
    begin
        repeat (20) @(posedge REF_CLK);
        NRST <= 1'b1;
        rd(12'h02c, 32'h0);
        rd(12'h028, 32'h0);
        rd(12'h024, 32'h0);
        rd(12'h034, 32'h0);
        rd(12'h0fc, 32'h0);
        // Same preload and count sequence on timer B, then timer C
        for (int i = 0; i < 2; i++)
        begin
            b = 12'h028 + 12'(i * 16);
            wr(b, 32'h5);
            rd(b + 12'h4, 32'h0);
            rd(b, 32'h0);
            wr(b + 12'h4, 32'ha);
            rd(b + 12'h4, 32'ha);
            rd(b, 32'h5);
            wr(b + 12'h4, 32'h3);
            rd(b + 12'h4, 32'h3);
            rd(b, 32'h5);
        end
        // Reload at FF from preload FF holds the count at FF
        wr(12'h038, 32'hf);
        wr(12'h03c, 32'hf);
        wr(12'h080, 32'h2);
        wr(12'h034, 32'hf);
        rd(12'h03c, 32'hf);
        rd(12'h038, 32'hf);
        chk(TC_IRQ_FLAG, 32'h1);
        chk(wd_seen > 0, 32'h1);
        rd(12'h008, 32'h4);
        wr(12'h010, 32'h8);
        repeat (2) @(negedge REF_CLK);
        chk(TOC_OE, 32'h1);
        chk(TOC_OUT, 32'h1);
        wr(12'h034, 32'h0);
        wr(12'h080, 32'h0);
        wr(12'h008, 32'h0);
        rd(12'h008, 32'h0);
        wr(12'h010, 32'h0);
        repeat (2) @(negedge REF_CLK);
        chk(TOC_OE, 32'h0);
        chk(TOC_OUT, 32'h0);
        // Capture on rising edges, second edge while status is set
        wr(12'h090, 32'h1);
        wr(12'h098, 32'h6);
        wr(12'h024, 32'h6);
        EVENT_IN <= 1'b1;
        repeat (8) @(posedge REF_CLK);
        chk(TB_IRQ_FLAG, 32'h1);
        rd(12'h084, 32'h1);
        EVENT_IN <= 1'b0;
        repeat (8) @(posedge REF_CLK);
        EVENT_IN <= 1'b1;
        repeat (8) @(posedge REF_CLK);
        rd(12'h084, 32'h3);
        rd(12'h028, 32'ha);
        rd(12'h02c, 32'h0);
        rd(12'h028, 32'ha);
        wr(12'h008, 32'h0);
        rd(12'h008, 32'h0);
        final_report;
    end
endmodule
